// ===== shared/fpm_pkg.sv
// Purpose: constants and types for the front-panel menu controller
// Assumes: 10 MHz core clock, settings held in plain binary units
// Notes:   frequency in kHz, gain in whole dB, step size in kHz
`default_nettype none
package fpm_pkg;
	// ****************************************
	// clock and times
	// ****************************************
	localparam int CLK_HZ      = 10_000_000;
	localparam int IDLE_S      = 30;        // edit session inactivity, s
	localparam int BOOT_MS     = 1000;      // each power-up screen, ms
	localparam int IDLE_CYC    = IDLE_S * CLK_HZ;
	localparam int BOOT_CYC    = BOOT_MS * (CLK_HZ / 1000);

	// ****************************************
	// setting ranges and defaults
	// ****************************************
	localparam int FREQ_W      = 15;
	localparam int FREQ_MIN    = 21000;
	localparam int FREQ_MAX    = 24000;
	localparam int FREQ_GRID   = 125;
	localparam int GAIN_W      = 5;
	localparam int GAIN_MIN    = 0;
	localparam int GAIN_MAX    = 30;
	localparam int STEP_W      = 10;
	localparam int STEP_MIN    = 1;
	localparam int STEP_MAX    = 999;
	localparam int ADDR_W      = 5;
	localparam int ADDR_MAX    = 31;
	localparam int REF_W       = 2;
	localparam int REF_INT     = 0;
	localparam int REF_AUTO    = 2;
	localparam int VAL_W       = 16;

	// ****************************************
	// cursor positions
	// ****************************************
	localparam int CUR_W       = 3;
	localparam int RET_FREQ    = 5;         // return marker after 5 digits
	localparam int RET_GAIN    = 2;
	localparam int RET_FLAG    = 1;
	localparam int RET_STEP    = 3;
	localparam int RET_ADDR    = 2;
	localparam int SAVE_YES    = 0;
	localparam int SAVE_NO     = 1;

	typedef enum logic [2:0] {MN_FREQ, MN_GAIN, MN_INV, MN_REMOTE,
		MN_STEP, MN_EXTREF, MN_LINK, MN_ADDR} fpm_menu_t;
	typedef enum logic [2:0] {ST_LAMP, ST_REV, ST_NORMAL, ST_MENU,
		ST_SAVE} fpm_state_t;
endpackage
`default_nettype wire

// ===== logic/fpm_sync.sv
// Purpose: two-stage synchroniser with rising-edge pulses
// Assumes: inputs asynchronous to clk
// Notes:   rise stays high while ce is low; consumers are frozen too
`timescale 1ns/1ps
`default_nettype none
module fpm_sync
#(
	parameter int W = 1
)
(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic         ce,
	// raw and synchronised levels
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q,
	output logic [W-1:0]      rise
);
	logic [W-1:0] meta_q;
	logic [W-1:0] prev_q;

	// only the second stage and later read meta_q
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			meta_q <= '0;
			q      <= '0;
			prev_q <= '0;
		end
		else if (ce)
		begin
			meta_q <= d;
			q      <= meta_q;
			prev_q <= q;
		end
	end

	// one pulse per switch operation
	assign rise = q & ~prev_q;
endmodule
`default_nettype wire

// ===== logic/fpm_timer.sv
// Purpose: restartable down counter with a done pulse
// Assumes: start wins over stop
// Notes:   done is high in the last counting cycle
`timescale 1ns/1ps
`default_nettype none
module fpm_timer
#(
	parameter int CYC = 16
)
(
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic ce,
	// control and status
	input  wire logic start,
	input  wire logic stop,
	output logic      busy,
	output logic      done
);
	localparam int CW = $clog2(CYC + 1);
	logic [CW-1:0] cnt_q;

	// load, clear or count down
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			cnt_q <= '0;
		else if (ce)
		begin
			if (start)
				cnt_q <= CW'(CYC);
			else if (stop)
				cnt_q <= '0;
			else if (busy)
				cnt_q <= cnt_q - CW'(1);
		end
	end

	assign busy = cnt_q != '0;
	// done reads only ce and the count, so start and stop may depend on it
	assign done = ce && cnt_q == CW'(1);
endmodule
`default_nettype wire

// ===== logic/fpm_menu.sv
// Purpose: front-panel menu controller: switches, settings, lamps
// Assumes: switches and lock flags come from pins; NV store on CORE_CLK
// Notes:   edit copies (e_*) run beside committed copies (c_*)
// Behaviour
// - eight menus in fixed order, then the save prompt
// - changes last only when begun by menu press and confirmed at save
// - thirty idle seconds in a session restore settings and abandon
// - committed gain written to nonvolatile store; all settings restored at power-up when the store is valid
// - power-up shows all segments, then revision, then normal screen
// - horizontal rocker moves the cursor one place left or right
// - vertical rocker raises or lowers the digit under the cursor
// - vertical rocker toggles on/off settings in either direction
// - edited frequency reaches hardware only after save confirmation
// - gain edits apply at once, stored only on yes at save
// - gain moves by 1 dB or 10 dB by cursor digit
// - gain limited to 0 to 30 dB
// - yes commits, no restores; confirm returns to normal screen
// - confirm on the return marker jumps to the save prompt
// - confirm off the return marker advances to the next menu, or from the address menu to the save prompt
// - alarm lamp lit while any oscillator loop is out of lock
// - mute lamp follows mute, remote lamp follows remote operation
// - optional menu sets tuning step, at least 1 kHz
// - frequency spans 21000 to 24000 kHz
`timescale 1ns/1ps
`default_nettype none
module fpm_menu
	import fpm_pkg::*;
#(
	parameter int               N_PLL       = 2,
	parameter bit               HAS_STEP    = 1'b1,
	parameter int               IDLE_CYCLES = IDLE_CYC,
	parameter int               BOOT_CYCLES = BOOT_CYC,
	parameter logic [VAL_W-1:0] REVISION    = 16'h0100 // arbitrary value
)
(
	// clock, reset, enable
	input  wire logic              CORE_CLK,
	input  wire logic              RESET,
	input  wire logic              CE,
	// operator switches, high while operated
	input  wire logic              SW_MENU,
	input  wire logic              SW_LEFT,
	input  wire logic              SW_RIGHT,
	input  wire logic              SW_UP,
	input  wire logic              SW_DOWN,
	// status inputs
	input  wire logic [N_PLL-1:0]  PLL_UNLOCK,
	input  wire logic              MUTE_SEL,
	// nonvolatile store, read at power-up
	input  wire logic              NV_VALID,
	input  wire logic [FREQ_W-1:0] NV_FREQ,
	input  wire logic [GAIN_W-1:0] NV_GAIN,
	input  wire logic              NV_INV,
	input  wire logic              NV_REMOTE,
	input  wire logic [STEP_W-1:0] NV_STEP,
	input  wire logic [REF_W-1:0]  NV_REF,
	input  wire logic              NV_LINK,
	input  wire logic [ADDR_W-1:0] NV_ADDR,
	// nonvolatile store, written on commit
	output logic                   NV_WRITE,
	output logic [GAIN_W-1:0]      NV_GAIN_SAVE,
	// settings to the hardware
	output logic [FREQ_W-1:0]      HW_FREQ,
	output logic [GAIN_W-1:0]      HW_GAIN,
	output logic                   HW_INV,
	output logic                   HW_REMOTE,
	output logic [STEP_W-1:0]      HW_STEP,
	output logic [REF_W-1:0]       HW_REF,
	output logic                   HW_LINK,
	output logic [ADDR_W-1:0]      HW_ADDR,
	// display
	output fpm_state_t             DISP_SCREEN,
	output fpm_menu_t              DISP_MENU,
	output logic [CUR_W-1:0]       DISP_CURSOR,
	output logic [VAL_W-1:0]       DISP_VALUE,
	// lamps
	output logic                   ALARM_LAMP,
	output logic                   POWER_LAMP,
	output logic                   MUTE_LAMP,
	output logic                   REMOTE_LAMP
);
	// ****************************************
	// declarations
	// ****************************************
	fpm_state_t        st_q;
	fpm_menu_t         menu_q;
	logic [CUR_W-1:0]  cursor_q;
	logic              booted_q;
	logic [FREQ_W-1:0] c_freq_q, e_freq_q;
	logic [GAIN_W-1:0] c_gain_q, e_gain_q;
	logic              c_inv_q, e_inv_q, c_remote_q, e_remote_q;
	logic [STEP_W-1:0] c_step_q, e_step_q;
	logic [REF_W-1:0]  c_ref_q, e_ref_q;
	logic              c_link_q, e_link_q;
	logic [ADDR_W-1:0] c_addr_q, e_addr_q;
	logic [VAL_W-1:0]  disp_q, disp_d;
	logic              nv_wr_q, alarm_q, mute_q, remote_q;
	logic [4:0]        sw_s, sw_p;
	logic [N_PLL-1:0]  unlock_s;
	logic              idle_busy, idle_done, boot_done;
	int                wt_w, dl_w, fdl_w;

	// ****************************************
	// helpers
	// ****************************************
	function automatic int pow10(input int e);
		unique case (e)
			1:       pow10 = 10;
			2:       pow10 = 100;
			3:       pow10 = 1000;
			4:       pow10 = 10000;
			default: pow10 = 1;
		endcase
	endfunction

	// add, but keep the old value if the result leaves the range
	function automatic int bump(input int v, input int d, input int lo,
		input int hi);
		int n;
		n = v + d;
		bump = (n < lo || n > hi) ? v : n;
	endfunction

	function automatic logic [CUR_W-1:0] ret_of(input fpm_menu_t m);
		unique case (m)
			MN_FREQ: ret_of = CUR_W'(RET_FREQ);
			MN_GAIN: ret_of = CUR_W'(RET_GAIN);
			MN_STEP: ret_of = CUR_W'(RET_STEP);
			MN_ADDR: ret_of = CUR_W'(RET_ADDR);
			default: ret_of = CUR_W'(RET_FLAG);
		endcase
	endfunction

	function automatic fpm_menu_t next_menu(input fpm_menu_t m);
		next_menu = fpm_menu_t'(m + 3'h1);
		if (next_menu == MN_STEP && !HAS_STEP)
			next_menu = MN_EXTREF;
	endfunction

	// ****************************************
	// inputs and timers
	// ****************************************
	fpm_sync #(.W(5)) u_sw (
		.clk   (CORE_CLK),
		.reset (RESET),
		.ce    (CE),
		.d     ({SW_DOWN, SW_UP, SW_RIGHT, SW_LEFT, SW_MENU}),
		.q     (sw_s),
		.rise  (sw_p)
	);
	fpm_sync #(.W(N_PLL)) u_lock (
		.clk   (CORE_CLK),
		.reset (RESET),
		.ce    (CE),
		.d     (PLL_UNLOCK),
		.q     (unlock_s),
		.rise  ()
	);

	wire p_menu    = sw_p[0];
	wire p_left    = sw_p[1];
	wire p_right   = sw_p[2];
	wire p_up      = sw_p[3];
	wire p_down    = sw_p[4];
	wire any_w     = |sw_p;
	wire sess_w    = st_q == ST_MENU || st_q == ST_SAVE;
	wire boot_w    = st_q == ST_LAMP && !booted_q;
	wire to_w      = sess_w && idle_done && !any_w;
	wire start_w   = st_q == ST_NORMAL && p_menu;
	wire save_w    = sess_w && p_menu && !to_w && st_q == ST_SAVE;
	wire commit_w  = save_w && cursor_q == CUR_W'(SAVE_YES);
	wire revert_w  = to_w || (save_w && cursor_q == CUR_W'(SAVE_NO));
	wire load_w    = start_w || revert_w || (st_q == ST_LAMP && boot_done);
	wire kick_w    = start_w || (sess_w && any_w && !save_w);
	wire [CUR_W-1:0] ret_w = (st_q == ST_SAVE) ? CUR_W'(SAVE_NO)
		: ret_of(menu_q);
	wire on_ret    = cursor_q == ret_w;
	wire edit_w    = st_q == ST_MENU && !p_menu && !to_w && !on_ret
		&& (p_up || p_down);
	wire fpm_menu_t menu_nx_w = next_menu(menu_q);

	fpm_timer #(.CYC(IDLE_CYCLES)) u_idle (
		.clk   (CORE_CLK),
		.reset (RESET),
		.ce    (CE),
		.start (kick_w),
		.stop  (commit_w || revert_w),
		.busy  (idle_busy),
		.done  (idle_done)
	);
	fpm_timer #(.CYC(BOOT_CYCLES)) u_boot (
		.clk   (CORE_CLK),
		.reset (RESET),
		.ce    (CE),
		.start (boot_w || (st_q == ST_LAMP && boot_done)),
		.stop  (1'b0),
		.busy  (),
		.done  (boot_done)
	);

	// ****************************************
	// digit arithmetic
	// ****************************************
	// digit weight from cursor, up raises, down lowers
	assign wt_w  = pow10(int'(ret_w) - 1 - int'(cursor_q));
	assign dl_w  = p_up ? wt_w : -wt_w;
	// frequency never moves by less than the tuning step
	assign fdl_w = (wt_w < int'(e_step_q)) ? (p_up ? int'(e_step_q)
		: -int'(e_step_q)) : dl_w;
	wire [FREQ_W-1:0] freq_nx_w = FREQ_W'(bump(int'(e_freq_q), fdl_w,
		FREQ_MIN, FREQ_MAX));
	wire [GAIN_W-1:0] gain_nx_w = GAIN_W'(bump(int'(e_gain_q), dl_w,
		GAIN_MIN, GAIN_MAX));
	wire [STEP_W-1:0] step_nx_w = STEP_W'(bump(int'(e_step_q), dl_w,
		STEP_MIN, STEP_MAX));
	wire [ADDR_W-1:0] addr_nx_w = ADDR_W'(bump(int'(e_addr_q), dl_w,
		0, ADDR_MAX));
	wire [REF_W-1:0] ref_nx_w = (e_ref_q == REF_W'(REF_AUTO))
		? REF_W'(REF_INT) : e_ref_q + REF_W'(1);

	// ****************************************
	// screen sequencer and cursor
	// ****************************************
	always_ff @(posedge CORE_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			st_q     <= ST_LAMP;
			menu_q   <= MN_FREQ;
			cursor_q <= '0;
			booted_q <= 1'b0;
		end
		else if (CE)
		begin
			booted_q <= 1'b1;
			unique case (st_q)
				ST_LAMP:   if (boot_done) st_q <= ST_REV;
				ST_REV:    if (boot_done) st_q <= ST_NORMAL;
				ST_NORMAL:
					if (start_w)
					begin
						st_q     <= ST_MENU;
						menu_q   <= MN_FREQ;
						cursor_q <= '0;
					end
				ST_MENU, ST_SAVE:
					if (to_w || save_w)
						st_q <= ST_NORMAL;
					else if (p_menu && (on_ret || menu_q == MN_ADDR))
					begin
						st_q     <= ST_SAVE;
						cursor_q <= CUR_W'(SAVE_YES);
					end
					else if (p_menu)
					begin
						menu_q   <= menu_nx_w;
						cursor_q <= '0;
					end
					else if (p_left && cursor_q != '0)
						cursor_q <= cursor_q - CUR_W'(1);
					else if (p_right && !on_ret)
						cursor_q <= cursor_q + CUR_W'(1);
			endcase
		end
	end

	// ****************************************
	// edit copies
	// ****************************************
	always_ff @(posedge CORE_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			{e_freq_q, e_gain_q, e_step_q} <= {FREQ_W'(FREQ_MIN),
				GAIN_W'(GAIN_MIN), STEP_W'(FREQ_GRID)};
			{e_inv_q, e_remote_q, e_link_q} <= '0;
			{e_ref_q, e_addr_q} <= {REF_W'(REF_INT), ADDR_W'(0)};
		end
		else if (CE && load_w)
		begin
			// session start, discard or end of lamp screen: copy the committed set
			{e_freq_q, e_gain_q, e_step_q} <= {c_freq_q, c_gain_q,
				c_step_q};
			{e_inv_q, e_remote_q, e_link_q} <= {c_inv_q, c_remote_q,
				c_link_q};
			{e_ref_q, e_addr_q} <= {c_ref_q, c_addr_q};
		end
		else if (CE && edit_w)
		begin
			unique case (menu_q)
				MN_FREQ:   e_freq_q   <= freq_nx_w;
				MN_GAIN:   e_gain_q   <= gain_nx_w;
				MN_INV:    e_inv_q    <= ~e_inv_q;
				MN_REMOTE: e_remote_q <= ~e_remote_q;
				MN_STEP:   e_step_q   <= step_nx_w;
				MN_EXTREF: e_ref_q    <= ref_nx_w;
				MN_LINK:   e_link_q   <= ~e_link_q;
				MN_ADDR:   e_addr_q   <= addr_nx_w;
			endcase
		end
	end

	// ****************************************
	// committed settings
	// ****************************************
	always_ff @(posedge CORE_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			{c_freq_q, c_gain_q, c_step_q} <= {FREQ_W'(FREQ_MIN),
				GAIN_W'(GAIN_MIN), STEP_W'(FREQ_GRID)};
			{c_inv_q, c_remote_q, c_link_q} <= '0;
			{c_ref_q, c_addr_q} <= {REF_W'(REF_INT), ADDR_W'(0)};
			nv_wr_q <= 1'b0;
		end
		else if (CE)
		begin
			nv_wr_q <= commit_w;
			if (boot_w && NV_VALID)
			begin
				{c_freq_q, c_gain_q, c_step_q} <= {NV_FREQ, NV_GAIN,
					NV_STEP};
				{c_inv_q, c_remote_q, c_link_q} <= {NV_INV, NV_REMOTE,
					NV_LINK};
				{c_ref_q, c_addr_q} <= {NV_REF, NV_ADDR};
			end
			else if (commit_w)
			begin
				{c_freq_q, c_gain_q, c_step_q} <= {e_freq_q, e_gain_q,
					e_step_q};
				{c_inv_q, c_remote_q, c_link_q} <= {e_inv_q, e_remote_q,
					e_link_q};
				{c_ref_q, c_addr_q} <= {e_ref_q, e_addr_q};
			end
		end
	end

	// ****************************************
	// display value and lamps
	// ****************************************
	always_comb
	begin
		disp_d = '0;
		if (st_q == ST_LAMP)
			disp_d = '1;
		else if (st_q == ST_REV)
			disp_d = REVISION;
		else if (st_q == ST_NORMAL)
			disp_d = VAL_W'(c_freq_q);
		else if (st_q == ST_MENU)
			unique case (menu_q)
				MN_FREQ:   disp_d = VAL_W'(e_freq_q);
				MN_GAIN:   disp_d = VAL_W'(e_gain_q);
				MN_INV:    disp_d = VAL_W'(e_inv_q);
				MN_REMOTE: disp_d = VAL_W'(e_remote_q);
				MN_STEP:   disp_d = VAL_W'(e_step_q);
				MN_EXTREF: disp_d = VAL_W'(e_ref_q);
				MN_LINK:   disp_d = VAL_W'(e_link_q);
				MN_ADDR:   disp_d = VAL_W'(e_addr_q);
			endcase
	end

	always_ff @(posedge CORE_CLK or posedge RESET)
	begin
		if (RESET)
			{disp_q, alarm_q, mute_q, remote_q} <= '0;
		else if (CE)
		begin
			disp_q   <= disp_d;
			alarm_q  <= |unlock_s;
			mute_q   <= MUTE_SEL;
			remote_q <= c_remote_q;
		end
	end

	// edit gain is the live gain; it equals committed outside sessions once the lamp screen ends
	assign HW_GAIN      = e_gain_q;
	assign HW_FREQ      = c_freq_q;
	assign {HW_INV, HW_REMOTE, HW_LINK} = {c_inv_q, c_remote_q, c_link_q};
	assign {HW_STEP, HW_REF, HW_ADDR}   = {c_step_q, c_ref_q, c_addr_q};
	assign NV_WRITE     = nv_wr_q;
	assign NV_GAIN_SAVE = c_gain_q;
	assign DISP_SCREEN  = st_q;
	assign DISP_MENU    = menu_q;
	assign DISP_CURSOR  = cursor_q;
	assign DISP_VALUE   = disp_q;
	assign ALARM_LAMP   = alarm_q;
	assign POWER_LAMP   = 1'b1;
	assign MUTE_LAMP    = mute_q;
	assign REMOTE_LAMP  = remote_q;

	// ****************************************
	// assertions
	// ****************************************
	wire any_unlock_w = |unlock_s;
	wire no_commit_w  = !boot_w && !commit_w;

	property p_alarm;
		@(posedge CORE_CLK) disable iff (RESET)
		CE |=> ALARM_LAMP == $past(any_unlock_w);
	endproperty
	a_alarm: assert property (p_alarm)
		else $error("alarm lamp does not follow lock loss");

	property p_hold;
		@(posedge CORE_CLK) disable iff (RESET)
		CE && no_commit_w |=> $stable(c_freq_q) && $stable(c_gain_q);
	endproperty
	a_hold: assert property (p_hold)
		else $error("committed setting changed without confirmation");

	property p_timeout;
		@(posedge CORE_CLK) disable iff (RESET)
		CE && to_w |=> st_q == ST_NORMAL && e_freq_q == c_freq_q
			&& e_gain_q == c_gain_q && !idle_busy;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("idle timeout did not restore settings");

	property p_ret;
		@(posedge CORE_CLK) disable iff (RESET)
		CE && st_q == ST_MENU && p_menu && on_ret && !to_w
			|=> st_q == ST_SAVE && cursor_q == CUR_W'(SAVE_YES);
	endproperty
	a_ret: assert property (p_ret)
		else $error("return marker did not reach save prompt");

	property p_adv;
		@(posedge CORE_CLK) disable iff (RESET)
		CE && st_q == ST_MENU && p_menu && !on_ret && !to_w
			&& menu_q != MN_ADDR |=> st_q == ST_MENU
			&& menu_q == $past(menu_nx_w) && cursor_q == '0;
	endproperty
	a_adv: assert property (p_adv)
		else $error("confirm did not advance to next menu");

	property p_cursor;
		@(posedge CORE_CLK) disable iff (RESET)
		CE && st_q == ST_MENU && !p_menu && !to_w && p_right && !p_left
			&& !on_ret |=> cursor_q == $past(cursor_q) + 3'h1;
	endproperty
	a_cursor: assert property (p_cursor)
		else $error("right rocker did not move cursor");

	property p_toggle;
		@(posedge CORE_CLK) disable iff (RESET)
		CE && edit_w && menu_q == MN_INV |=> e_inv_q != $past(e_inv_q);
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("vertical rocker did not toggle");

	property p_gain_rng;
		@(posedge CORE_CLK) disable iff (RESET)
		e_gain_q <= GAIN_W'(GAIN_MAX)
			&& (st_q != ST_NORMAL || HW_GAIN == NV_GAIN_SAVE);
	endproperty
	a_gain_rng: assert property (p_gain_rng)
		else $error("gain outside range");

	property p_gain_ten;
		@(posedge CORE_CLK) disable iff (RESET)
		CE && edit_w && menu_q == MN_GAIN && p_up && cursor_q == '0
			&& e_gain_q <= 5'h14 |=> e_gain_q == $past(e_gain_q) + 5'h0A;
	endproperty
	a_gain_ten: assert property (p_gain_ten)
		else $error("tens digit did not step gain by ten");

	property p_save_no;
		@(posedge CORE_CLK) disable iff (RESET)
		CE && save_w && cursor_q == CUR_W'(SAVE_NO) |=> st_q == ST_NORMAL
			&& $stable(c_freq_q) && e_freq_q == c_freq_q && !NV_WRITE;
	endproperty
	a_save_no: assert property (p_save_no)
		else $error("no at save prompt did not discard");

	property p_nv_load;
		@(posedge CORE_CLK) disable iff (RESET)
		CE && boot_w && NV_VALID |=> c_freq_q == $past(NV_FREQ)
			&& c_gain_q == $past(NV_GAIN);
	endproperty
	a_nv_load: assert property (p_nv_load)
		else $error("stored settings not restored");

	property p_boot;
		@(posedge CORE_CLK) disable iff (RESET)
		st_q == ST_REV |=> st_q == ST_REV || st_q == ST_NORMAL;
	endproperty
	a_boot: assert property (p_boot)
		else $error("power-up screen order broken");

	c_commit: cover property (@(posedge CORE_CLK) disable iff (RESET)
		commit_w ##1 NV_WRITE);
	c_timeout: cover property (@(posedge CORE_CLK) disable iff (RESET)
		to_w);
	c_jump: cover property (@(posedge CORE_CLK) disable iff (RESET)
		st_q == ST_MENU && p_menu && on_ret && menu_q == MN_GAIN);
endmodule
`default_nettype wire

// ===== bench/fpm_oper.sv
// Purpose: operator at the front panel, one switch press per call
// Assumes: switch index 0 menu, 1 left, 2 right, 3 up, 4 down
// Notes:   press held 4 cycles, then released 4 cycles
`timescale 1ns/1ps
`default_nettype none
module fpm_oper
(
	// clock
	input  wire logic       clk,
	// switch levels, high while operated
	output logic      [4:0] sw
);
	// switches rest released
	initial sw = 5'h00;

	// one press with a release the synchroniser sees
	task automatic press(input int k);
		@(negedge clk);
		sw[k] = 1'b1;
		repeat (4) @(negedge clk);
		sw[k] = 1'b0;
		repeat (4) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// ===== bench/tb_front_panel_menu_controller.sv
// Purpose: self-checking bench for the front-panel menu controller
// Assumes: short boot and idle counts; operator model drives switches
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	err_count++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_front_panel_menu_controller
	import fpm_pkg::*;
;
	// ****************************************
	// stimulus and observed signals
	// ****************************************
	logic clk = 0, rst = 1, mute = 0, ce = 1, nvv = 1;
	logic nv_i = 0, nv_r = 1, nv_l = 1;
	logic [1:0] unl = 2'h0, nv_rf = 2'h2;
	logic [FREQ_W-1:0] nv_f = 15'h55F0;
	logic [GAIN_W-1:0] nv_g = 5'h05;
	logic [STEP_W-1:0] nv_s = 10'h07D;
	logic [ADDR_W-1:0] nv_a = 5'h03;
	logic [4:0] sw;
	logic nvw, hinv, hrem, hl, alm, pwr, mlmp, rlmp;
	logic [GAIN_W-1:0] nvg, hg;
	logic [FREQ_W-1:0] hf;
	logic [STEP_W-1:0] hs;
	logic [REF_W-1:0] hrf;
	logic [ADDR_W-1:0] ha;
	fpm_state_t scr;
	fpm_menu_t mnu;
	logic [CUR_W-1:0] cur;
	logic [VAL_W-1:0] val;
	int err_count = 0, cmp_count = 0, wr = 0;

	fpm_oper op (.clk(clk), .sw(sw));
	fpm_menu #(.IDLE_CYCLES(50), .BOOT_CYCLES(8), .REVISION(16'h0123))
		uut (.CORE_CLK(clk),
		.RESET(rst), .CE(ce), .SW_MENU(sw[0]), .SW_LEFT(sw[1]),
		.SW_RIGHT(sw[2]), .SW_UP(sw[3]), .SW_DOWN(sw[4]),
		.PLL_UNLOCK(unl), .MUTE_SEL(mute), .NV_VALID(nvv),
		.NV_FREQ(nv_f), .NV_GAIN(nv_g), .NV_INV(nv_i),
		.NV_REMOTE(nv_r), .NV_STEP(nv_s), .NV_REF(nv_rf),
		.NV_LINK(nv_l), .NV_ADDR(nv_a), .NV_WRITE(nvw),
		.NV_GAIN_SAVE(nvg), .HW_FREQ(hf), .HW_GAIN(hg), .HW_INV(hinv),
		.HW_REMOTE(hrem), .HW_STEP(hs), .HW_REF(hrf), .HW_LINK(hl),
		.HW_ADDR(ha),
		.DISP_SCREEN(scr), .DISP_MENU(mnu), .DISP_CURSOR(cur),
		.DISP_VALUE(val), .ALARM_LAMP(alm), .POWER_LAMP(pwr),
		.MUTE_LAMP(mlmp), .REMOTE_LAMP(rlmp));

	// clock and store-write pulse counter
	initial forever #50 clk = ~clk;
	always @(negedge clk) if (nvw === 1'b1) wr++;

	task automatic wait_scr(input fpm_state_t s);
		int i;
		for (i = 0; i < 40 && scr !== s; i++) @(negedge clk);
	endtask

	task automatic t_boot;
		repeat (2) @(negedge clk);
		`CHK("lamp", 16'hFFFF, val)
		wait_scr(ST_REV);
		@(negedge clk);
		`CHK("rev", 16'h0123, val)
		wait_scr(ST_NORMAL);
		`CHK("freq", 15'h55F0, hf)
		`CHK("gain", 5'h05, hg)
		`CHK("step", 10'h07D, hs)
		`CHK("ref", 2'h2, hrf)
		`CHK("link", 1'b1, hl)
		`CHK("addr", 5'h03, ha)
		`CHK("remote", 1'b1, hrem)
		`CHK("rlamp", 1'b1, rlmp)
	endtask

	task automatic t_gain;
		op.press(0);
		`CHK("scr", ST_MENU, scr)
		op.press(0);
		`CHK("menu", MN_GAIN, mnu)
		op.press(3);
		`CHK("gain", 5'h0F, hg)
		op.press(3);
		op.press(3);
		`CHK("gain", 5'h19, hg)
		op.press(2);
		op.press(3);
		`CHK("gain", 5'h1A, hg)
		op.press(1);
		`CHK("cur", 3'h0, cur)
		op.press(2);
		op.press(2);
		`CHK("nvg", 5'h05, nvg)
		op.press(0);
		`CHK("scr", ST_SAVE, scr)
		op.press(0);
		`CHK("scr", ST_NORMAL, scr)
		`CHK("nvg", 5'h1A, nvg)
		`CHK("wr", 1, wr)
	endtask

	task automatic t_order;
		int m;
		op.press(0);
		for (m = 0; m < 8; m++)
		begin
			`CHK("menu", m, mnu)
			if (m == 0)
			begin
				op.press(2);
				op.press(3);
				`CHK("fval", 16'h59D8, val)
				`CHK("freq", 15'h55F0, hf)
			end
			if (m == 2) op.press(4);
			if (m == 2) `CHK("inv", 16'h0001, val)
			op.press(0);
		end
		`CHK("scr", ST_SAVE, scr)
		op.press(2);
		op.press(0);
		`CHK("inv", 1'b0, hinv)
		`CHK("freq", 15'h55F0, hf)
		`CHK("wr", 1, wr)
	endtask

	task automatic t_idle;
		op.press(0);
		op.press(0);
		op.press(4);
		`CHK("gain", 5'h10, hg)
		repeat (60) @(negedge clk);
		`CHK("scr", ST_NORMAL, scr)
		`CHK("gain", 5'h1A, hg)
		`CHK("wr", 1, wr)
	endtask

	task automatic t_lamp;
		unl = 2'h2;
		repeat (5) @(negedge clk);
		`CHK("alarm", 1'b1, alm)
		unl = 2'h0;
		mute = 1'b1;
		repeat (5) @(negedge clk);
		`CHK("alarm", 1'b0, alm)
		`CHK("mlamp", 1'b1, mlmp)
		`CHK("plamp", 1'b1, pwr)
	endtask

	// enable low freezes switches and lamps
	task automatic t_ce;
		ce = 1'b0;
		unl = 2'h1;
		op.press(0);
		`CHK("scr", ST_NORMAL, scr)
		`CHK("alarm", 1'b0, alm)
		unl = 2'h0;
		ce = 1'b1;
		repeat (5) @(negedge clk);
		`CHK("scr", ST_NORMAL, scr)
	endtask

	// mid-run reset with no valid stored set gives defaults
	task automatic t_reset;
		nvv = 1'b0;
		nv_f = 15'h5DC0;
		rst = 1'b1;
		@(negedge clk);
		`CHK("rval", 16'h0000, val)
		`CHK("alarm", 1'b0, alm)
		rst = 1'b0;
		wait_scr(ST_NORMAL);
		`CHK("freq", 15'h5208, hf)
		`CHK("gain", 5'h00, hg)
		`CHK("step", 10'h07D, hs)
		`CHK("addr", 5'h00, ha)
		`CHK("rlamp", 1'b0, rlmp)
	endtask

	task automatic end_of_test;
		$display("errors %0d checks %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// main sequence
	initial
	begin
		repeat (6) @(negedge clk);
		rst = 0;
		t_boot;
		t_gain;
		t_order;
		t_idle;
		t_lamp;
		t_ce;
		t_reset;
		end_of_test;
	end

	// watchdog against a hang
	initial
	begin
		repeat (6000) @(posedge clk);
		err_count++;
		end_of_test;
	end
endmodule
`default_nettype wire
